//--- verilog/msm_pkg.sv
// Package: constants and carriers for the service mailbox
package msm_pkg;

  // **********************************************************
  // Function codes and fixed addresses
  // **********************************************************
  localparam logic [7:0]  FC_RD_COIL     = 8'h01;
  localparam logic [7:0]  FC_RD_HOLD     = 8'h03;
  localparam logic [7:0]  FC_RD_INPUT    = 8'h04;
  localparam logic [7:0]  FC_WR_COIL     = 8'h05;
  localparam logic [7:0]  FC_WR_REG      = 8'h06;
  localparam logic [7:0]  FC_DIAG        = 8'h08;
  localparam logic [7:0]  FC_WR_COILS    = 8'h0f;
  localparam logic [7:0]  FC_WR_REGS     = 8'h10;
  localparam logic [15:0] DIAG_ECHO_SUB  = 16'h0000;
  localparam logic [15:0] LEN_REG_ADDR   = 16'h0000;
  localparam logic [15:0] BUF_FIRST_ADDR = 16'h0001;
  localparam logic [15:0] BUF_LAST_ADDR  = 16'h0201;
  localparam logic [15:0] TRIG_COIL_ADDR = 16'h1000;
  localparam logic [15:0] NUM_BASE_ADDR  = 16'h2000;
  localparam logic [15:0] TXT_BASE_ADDR  = 16'h2100;
  localparam logic [15:0] PROD_IDX_ADDR  = 16'h2200;
  localparam logic [15:0] COIL_OFF       = 16'h0000;

  // **********************************************************
  // Packet layout
  // **********************************************************
  localparam int          BUF_WORDS      = 513;
  localparam int          IDX_W          = 10;
  localparam logic [15:0] MIN_PKT_BYTES  = 16'h0002;
  localparam logic [15:0] MAX_PKT_BYTES  = 16'h0400;
  localparam logic [10:0] ROUTE_BYTES    = 11'h002;
  localparam logic [10:0] MAX_DATA_BYTES = 11'h3fe;
  localparam int          DIR_BIT        = 15;
  localparam int          STAT_HI        = 13;
  localparam int          STAT_LO        = 12;
  localparam int          SVC_HI         = 11;
  localparam logic [1:0]  RS_NORMAL      = 2'h0;
  localparam logic [1:0]  RS_UNKNOWN     = 2'h1;
  localparam logic [1:0]  RS_ERROR       = 2'h2;
  localparam logic        DIR_RESPONSE   = 1'h1;
  localparam logic        UNUSED_BIT     = 1'h0;
  localparam logic [15:0] ITEM_STEP      = 16'h0001;
  localparam logic [15:0] ITEM_RESET     = 16'h0001;

  // **********************************************************
  // Carriers
  // **********************************************************
  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
  } msm_req_s;

  typedef struct packed {
    logic [15:0] data;
    logic        exc;
    logic        echo;
  } msm_rsp_s;

  typedef struct packed {
    logic [11:0] num;
    logic [10:0] len;
  } msm_svc_s;

endpackage

//--- verilog/msm_service_mailbox.sv
// Service mailbox: packet buffers, trigger coil, router, staged values
//
// Notes on behaviour
// - diagnostics subfunction zero echoes the received query back unchanged.
// - numeric multi-register value changes only when its last element arrives.
// - text string target updates only when its final element is written.
// - offset values are zero based; value 0 selects item one.
// - trigger coil on submits command packet and produces response.
// - response packet is readable from input register 1 onward.
// - input register 0 reports response packet byte count.
// - packet is routing word plus at most 1022 data bytes.
// - first packet word is the routing control word.
// - router forwards service data to the named service handler.
// - routing word bit 15 is zero for commands, one for responses.
// - router status 00 normal, 01 unknown service, 10 router error.
// - low 12 routing bits carry the service number.
`timescale 1ns/100ps
`default_nettype none

// **********************************************************
// Staged multi-register target
// **********************************************************
module msm_stage #(
  parameter logic [15:0] BASE  = 16'h0000,
  parameter int          ELEMS = 4
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                wr_en,
  input  wire logic [15:0]         addr,
  input  wire logic [15:0]         data,
  output logic                     hit,
  output logic [15:0]              rd_data,
  output logic [16*ELEMS-1:0]      value,
  output logic                     commit
);
  localparam int IW = (ELEMS > 1) ? $clog2(ELEMS) : 1;

  logic [15:0]         stage_q [ELEMS];
  logic [16*ELEMS-1:0] value_q;
  logic                commit_q;
  wire  logic [15:0]   off  = addr - BASE;
  wire  logic [IW-1:0] idx  = off[IW-1:0];
  wire  logic          last = (off == 16'(ELEMS - 1));

  assign hit     = (addr >= BASE) && (off < 16'(ELEMS));
  assign rd_data = value_q[idx*16 +: 16];
  assign value   = value_q;
  assign commit  = commit_q;

  // Earlier elements wait in a shadow so a half-written value never shows
  always_ff @(posedge core_clk)
  begin
    commit_q <= 1'b0;
    if (rst)
    begin
      value_q <= '0;
    end
    else if (wr_en && hit && last)
    begin
      for (int i = 0; i < ELEMS - 1; i++)
        value_q[i*16 +: 16] <= stage_q[i];
      value_q[(ELEMS-1)*16 +: 16] <= data;
      commit_q <= 1'b1;
    end
    else if (wr_en && hit)
    begin
      stage_q[idx] <= data;
    end
  end
endmodule

// **********************************************************
// Mailbox top
// **********************************************************
module msm_service_mailbox #(
  parameter int NUM_ELEMS = 4,
  parameter int TXT_ELEMS = 8
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       req_valid,
  input  wire msm_pkg::msm_req_s          req,
  output logic                            rsp_valid,
  output msm_pkg::msm_rsp_s               rsp,
  output logic                            svc_start,
  output msm_pkg::msm_svc_s               svc,
  input  wire logic [msm_pkg::IDX_W-1:0]  svc_rd_idx,
  output logic [15:0]                     svc_rd_data,
  input  wire logic                       svc_wr_en,
  input  wire logic [msm_pkg::IDX_W-1:0]  svc_wr_idx,
  input  wire logic [15:0]                svc_wr_data,
  input  wire logic                       svc_done,
  input  wire logic                       svc_absent,
  input  wire logic [10:0]                svc_rsp_len,
  output logic                            busy,
  output logic [16*NUM_ELEMS-1:0]         num_value,
  output logic                            num_commit,
  output logic [16*TXT_ELEMS-1:0]         txt_value,
  output logic                            txt_commit,
  output logic [15:0]                     product_item
);
  typedef enum logic [1:0] {ST_IDLE, ST_ROUTE, ST_SERVE, ST_DONE} msm_st_e;

  msm_st_e           state_q;
  logic [15:0]       cmd_mem [msm_pkg::BUF_WORDS];
  logic [15:0]       rsp_mem [msm_pkg::BUF_WORDS];
  logic [15:0]       cmd_len_q;
  logic [15:0]       rsp_len_q;
  logic [15:0]       prod_item_q;
  logic [11:0]       rsp_num_q;
  logic [10:0]       data_len_q;
  logic [1:0]        status_q;
  logic              svc_start_q;
  msm_pkg::msm_svc_s svc_q;
  logic [15:0]       svc_rd_q;
  logic              rsp_valid_q;
  msm_pkg::msm_rsp_s rsp_q;
  msm_pkg::msm_rsp_s rsp_d;
  logic              num_hit;
  logic              txt_hit;
  logic [15:0]       num_rd;
  logic [15:0]       txt_rd;

  // **********************************************************
  // Request decode
  // **********************************************************
  wire logic [7:0]  fc     = req.func;
  wire logic [15:0] ad     = req.addr;
  wire logic wr_reg  = req_valid &&
                       (fc == msm_pkg::FC_WR_REG || fc == msm_pkg::FC_WR_REGS);
  wire logic wr_coil = req_valid &&
                       (fc == msm_pkg::FC_WR_COIL || fc == msm_pkg::FC_WR_COILS);
  wire logic rd_hold = req_valid && fc == msm_pkg::FC_RD_HOLD;
  wire logic rd_inp  = req_valid && fc == msm_pkg::FC_RD_INPUT;
  wire logic rd_coil = req_valid && fc == msm_pkg::FC_RD_COIL;
  wire logic diag    = req_valid && fc == msm_pkg::FC_DIAG;
  wire logic in_buf  = ad >= msm_pkg::BUF_FIRST_ADDR &&
                       ad <= msm_pkg::BUF_LAST_ADDR;
  wire logic [msm_pkg::IDX_W-1:0] buf_idx =
    msm_pkg::IDX_W'(ad - msm_pkg::BUF_FIRST_ADDR);
  wire logic is_len  = ad == msm_pkg::LEN_REG_ADDR;
  wire logic is_prod = ad == msm_pkg::PROD_IDX_ADDR;
  wire logic is_trig = ad == msm_pkg::TRIG_COIL_ADDR;
  wire logic wr_len  = wr_reg && is_len;
  wire logic wr_buf  = wr_reg && in_buf;
  wire logic wr_prod = wr_reg && is_prod;
  wire logic trig    = wr_coil && is_trig && req.data != msm_pkg::COIL_OFF &&
                       state_q == ST_IDLE;
  wire logic hold_ok = is_len || in_buf || num_hit || txt_hit || is_prod;
  wire logic inp_ok  = is_len || in_buf;
  wire logic echo    = diag && ad == msm_pkg::DIAG_ECHO_SUB;

  wire logic [15:0] hold_data = is_len  ? cmd_len_q :
                                in_buf  ? cmd_mem[buf_idx] :
                                num_hit ? num_rd :
                                txt_hit ? txt_rd : prod_item_q - msm_pkg::ITEM_STEP;
  wire logic [15:0] inp_data  = is_len ? rsp_len_q : rsp_mem[buf_idx];

  // **********************************************************
  // Routing word fields
  // **********************************************************
  wire logic [15:0] route     = cmd_mem[0];
  wire logic        hdr_bad   = route[msm_pkg::DIR_BIT] ||
                                route[msm_pkg::STAT_HI:msm_pkg::STAT_LO] !=
                                msm_pkg::RS_NORMAL;
  wire logic        len_bad   = cmd_len_q < msm_pkg::MIN_PKT_BYTES ||
                                cmd_len_q > msm_pkg::MAX_PKT_BYTES;
  wire logic [10:0] clip_len  = (svc_rsp_len > msm_pkg::MAX_DATA_BYTES) ?
                                msm_pkg::MAX_DATA_BYTES : svc_rsp_len;

  msm_stage #(.BASE(msm_pkg::NUM_BASE_ADDR), .ELEMS(NUM_ELEMS)) u_num (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (wr_reg),
    .addr     (ad),
    .data     (req.data),
    .hit      (num_hit),
    .rd_data  (num_rd),
    .value    (num_value),
    .commit   (num_commit)
  );

  msm_stage #(.BASE(msm_pkg::TXT_BASE_ADDR), .ELEMS(TXT_ELEMS)) u_txt (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (wr_reg),
    .addr     (ad),
    .data     (req.data),
    .hit      (txt_hit),
    .rd_data  (txt_rd),
    .value    (txt_value),
    .commit   (txt_commit)
  );

  // **********************************************************
  // Answer to the host
  // **********************************************************
  always_comb
  begin
    rsp_d = '0;
    if (echo)
    begin
      rsp_d.data = req.data;
      rsp_d.echo = 1'b1;
    end
    else if (rd_hold)
    begin
      rsp_d.data = hold_data;
      rsp_d.exc  = !hold_ok;
    end
    else if (rd_inp)
    begin
      rsp_d.data = inp_data;
      rsp_d.exc  = !inp_ok;
    end
    else if (rd_coil)
    begin
      rsp_d.data = {15'h0000, busy};
      rsp_d.exc  = !is_trig;
    end
    else if (wr_reg)
    begin
      rsp_d.data = req.data;
      rsp_d.exc  = !hold_ok;
    end
    else if (wr_coil)
    begin
      rsp_d.data = req.data;
      rsp_d.exc  = !is_trig;
    end
    else
    begin
      rsp_d.exc  = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    rsp_valid_q <= !rst && req_valid;
    rsp_q       <= rst ? '0 : rsp_d;
  end

  // **********************************************************
  // Host-side storage
  // **********************************************************
  always_ff @(posedge core_clk)
  begin
    if (wr_buf)
      cmd_mem[buf_idx] <= req.data;
    svc_rd_q <= cmd_mem[svc_rd_idx];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cmd_len_q   <= '0;
      prod_item_q <= msm_pkg::ITEM_RESET;
    end
    else
    begin
      if (wr_len)
        cmd_len_q <= req.data;
      if (wr_prod)
        prod_item_q <= req.data + msm_pkg::ITEM_STEP;
    end
  end

  // **********************************************************
  // Router
  // **********************************************************
  // A second trigger while busy is ignored rather than queued
  always_ff @(posedge core_clk)
  begin
    svc_start_q <= 1'b0;
    if (rst)
    begin
      state_q    <= ST_IDLE;
      status_q   <= msm_pkg::RS_NORMAL;
      data_len_q <= '0;
      svc_q      <= '0;
      rsp_num_q  <= '0;
      rsp_len_q  <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (trig)
            state_q <= ST_ROUTE;
        ST_ROUTE:
          if (hdr_bad || len_bad)
          begin
            status_q   <= msm_pkg::RS_ERROR;
            rsp_num_q  <= route[msm_pkg::SVC_HI:0];
            data_len_q <= '0;
            state_q    <= ST_DONE;
          end
          else
          begin
            svc_q.num   <= route[msm_pkg::SVC_HI:0];
            rsp_num_q   <= route[msm_pkg::SVC_HI:0];
            svc_q.len   <= 11'(cmd_len_q) - msm_pkg::ROUTE_BYTES;
            svc_start_q <= 1'b1;
            state_q     <= ST_SERVE;
          end
        ST_SERVE:
          if (svc_done)
          begin
            status_q   <= svc_absent ? msm_pkg::RS_UNKNOWN : msm_pkg::RS_NORMAL;
            data_len_q <= svc_absent ? '0 : clip_len;
            state_q    <= ST_DONE;
          end
        ST_DONE:
          begin
            rsp_len_q <= 16'(msm_pkg::ROUTE_BYTES + data_len_q);
            state_q   <= ST_IDLE;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Handler fills data words; the router stamps the routing word last
  always_ff @(posedge core_clk)
  begin
    if (state_q == ST_DONE)
      rsp_mem[0] <= {msm_pkg::DIR_RESPONSE, msm_pkg::UNUSED_BIT, status_q,
                     rsp_num_q};
    else if (state_q == ST_SERVE && svc_wr_en)
      rsp_mem[svc_wr_idx] <= svc_wr_data;
  end

  assign rsp_valid    = rsp_valid_q;
  assign rsp          = rsp_q;
  assign svc_start    = svc_start_q;
  assign svc          = svc_q;
  assign svc_rd_data  = svc_rd_q;
  assign busy         = state_q != ST_IDLE;
  assign product_item = prod_item_q;

  // **********************************************************
  // Assertions
  // **********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_route_ok;
    state_q == ST_ROUTE && !hdr_bad && !len_bad;
  endsequence

  sequence s_route_bad;
    state_q == ST_ROUTE && (hdr_bad || len_bad);
  endsequence

  a_echo_loopback: assert property (echo |=> rsp_valid && rsp.echo &&
    rsp.data == $past(req.data)) else $error("echo data wrong");
  a_num_held: assert property ($changed(num_value) |-> num_commit)
    else $error("numeric value changed before last element");
  a_txt_held: assert property ($changed(txt_value) |-> txt_commit)
    else $error("text changed before last element");
  a_item_zero_based: assert property (wr_prod |=>
    product_item == $past(req.data) + msm_pkg::ITEM_STEP)
    else $error("item number not offset plus one");
  a_trigger_submit: assert property (trig |=> state_q == ST_ROUTE ##1
    (svc_start || state_q == ST_DONE)) else $error("trigger ignored");
  a_route_forward: assert property (s_route_ok |=> svc_start &&
    svc.num == $past(route[msm_pkg::SVC_HI:0])) else $error("bad dispatch");
  a_route_error: assert property (s_route_bad |=> !svc_start ##1
    rsp_len_q == 16'(msm_pkg::ROUTE_BYTES) && !busy)
    else $error("router error not reported");
  a_len_report: assert property (state_q == ST_DONE |=>
    rsp_len_q == 16'(msm_pkg::ROUTE_BYTES + $past(data_len_q)))
    else $error("response length wrong");
  a_buf_pairing: assert property (wr_buf ##1 (rd_hold && in_buf &&
    ad == $past(ad)) |=> rsp.data == $past(req.data, 2))
    else $error("buffer word not kept");
  a_resp_dir: assert property (state_q == ST_DONE |=>
    rsp_mem[0][msm_pkg::DIR_BIT]) else $error("direction bit clear");
endmodule

`default_nettype wire

//--- tb/msm_host_model.sv
// Host model: issues one register or coil request per cycle
`timescale 1ns/100ps
`default_nettype none

// **********************************************************
// Request port driver
// **********************************************************
module msm_host_model (
  input  wire logic              core_clk,
  output logic                   req_valid,
  output msm_pkg::msm_req_s      req,
  input  wire logic              rsp_valid,
  input  wire msm_pkg::msm_rsp_s rsp
);
  initial
  begin
    req_valid = 1'b0;
    req       = '0;
  end

  // Request set at a falling edge, taken at the next rising edge,
  // answer read at the falling edge after that
  task automatic xfer(input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] d, output logic v,
                      output msm_pkg::msm_rsp_s r);
    req_valid = 1'b1;
    req       = '{func: f, addr: a, data: d};
    @(negedge core_clk);
    v = rsp_valid;
    r = rsp;
  endtask

  // A released bus shows no stale request
  task automatic idle;
    req_valid = 1'b0;
    req       = ~req;
    @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

//--- tb/msm_service_mailbox_test.sv
// Self-checking bench for the service mailbox
`timescale 1ns/100ps
`default_nettype none

// **********************************************************
// Bench top
// **********************************************************
module msm_service_mailbox_test;
  logic                      core_clk;
  logic                      rst;
  logic                      req_valid;
  msm_pkg::msm_req_s         req;
  logic                      rsp_valid;
  msm_pkg::msm_rsp_s         rsp;
  logic                      svc_start;
  msm_pkg::msm_svc_s         svc;
  logic [msm_pkg::IDX_W-1:0] svc_rd_idx;
  logic [15:0]               svc_rd_data;
  logic                      svc_wr_en;
  logic [msm_pkg::IDX_W-1:0] svc_wr_idx;
  logic [15:0]               svc_wr_data;
  logic                      svc_done;
  logic                      svc_absent;
  logic [10:0]               svc_rsp_len;
  logic                      busy;
  logic [63:0]               num_value;
  logic                      num_commit;
  logic [127:0]              txt_value;
  logic                      txt_commit;
  logic [15:0]               product_item;
  int                        miscompares;
  int                        n_compared;
  int                        cycles;
  int                        starts;
  integer                    seed;
  logic [15:0]               w;
  logic [127:0]              nv;

  msm_service_mailbox msm_service_mailbox_i (.core_clk(core_clk),
    .rst(rst), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
    .rsp(rsp), .svc_start(svc_start), .svc(svc),
    .svc_rd_idx(svc_rd_idx), .svc_rd_data(svc_rd_data),
    .svc_wr_en(svc_wr_en), .svc_wr_idx(svc_wr_idx),
    .svc_wr_data(svc_wr_data), .svc_done(svc_done),
    .svc_absent(svc_absent), .svc_rsp_len(svc_rsp_len), .busy(busy),
    .num_value(num_value), .num_commit(num_commit),
    .txt_value(txt_value), .txt_commit(txt_commit),
    .product_item(product_item));

  msm_host_model msm_host_model_i (.core_clk(core_clk),
    .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Counts service starts so a second trigger that is not ignored shows up as a wrong total
  always @(negedge core_clk)
  begin
    cycles++;
    if (svc_start === 1'b1)
      starts++;
    if (cycles == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [127:0] exp,
                     input logic [127:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic op(input logic [7:0] f, input logic [15:0] a,
                    input logic [15:0] d, input logic [15:0] ed,
                    input logic ex);
    logic              v;
    msm_pkg::msm_rsp_s r;
    msm_host_model_i.xfer(f, a, d, v, r);
    chk("rsp_valid", 1, v);
    chk("rsp_exc", ex, r.exc);
    chk("rsp_echo", f == msm_pkg::FC_DIAG, r.echo);
    if (!ex)
      chk("rsp_data", ed, r.data);
  endtask

  task automatic service(input logic [15:0] route, input int nb,
                         input logic absent, input int rb,
                         input logic [1:0] st, input logic [7:0] fc);
    logic [15:0] cmd[$];
    logic [15:0] res[$];
    int          s0;
    int          k;
    cmd = {route};
    for (int j = 0; j < nb / 2; j++)
      cmd.push_back(16'($random(seed)));
    for (int j = 0; j < cmd.size(); j++)
      op(msm_pkg::FC_WR_REGS, 16'(j + 1), cmd[j], cmd[j], 0);
    op(msm_pkg::FC_WR_REG, msm_pkg::LEN_REG_ADDR, 16'(nb + 2),
       16'(nb + 2), 0);
    s0 = starts;
    op(fc, msm_pkg::TRIG_COIL_ADDR, 16'hff00, 16'hff00, 0);
    op(fc, msm_pkg::TRIG_COIL_ADDR, 16'hff00, 16'hff00, 0);
    op(msm_pkg::FC_RD_COIL, msm_pkg::TRIG_COIL_ADDR, 0, 1, 0);
    msm_host_model_i.idle();
    if (st != msm_pkg::RS_ERROR)
    begin
      chk("svc_start", s0 + 1, starts);
      chk("svc_num", route[11:0], svc.num);
      chk("svc_len", nb, svc.len);
      for (int j = 1; j < cmd.size(); j++)
      begin
        svc_rd_idx = 10'(j);
        @(negedge core_clk);
        chk("svc_rd_data", cmd[j], svc_rd_data);
      end
      svc_wr_en = 1'b1;
      for (int j = 1; j <= rb / 2; j++)
      begin
        res.push_back(16'($random(seed)));
        svc_wr_idx  = 10'(j);
        svc_wr_data = res[j-1];
        @(negedge core_clk);
      end
      svc_wr_en   = 1'b0;
      svc_done    = 1'b1;
      svc_absent  = absent;
      svc_rsp_len = 11'(rb);
      @(negedge core_clk);
      svc_done = 1'b0;
    end
    for (k = 0; k < 20 && busy !== 1'b0; k++)
      @(negedge core_clk);
    chk("busy", 0, busy);
    chk("starts", s0 + (st != msm_pkg::RS_ERROR), starts);
    op(msm_pkg::FC_RD_INPUT, 16'h0000, 0, 16'(2 + rb), 0);
    op(msm_pkg::FC_RD_INPUT, 16'h0001, 0,
       {1'b1, 1'b0, st, route[11:0]}, 0);
    for (int j = 0; j < res.size(); j++)
      op(msm_pkg::FC_RD_INPUT, 16'(j + 2), 0, res[j], 0);
  endtask

  initial
  begin
    seed        = 32'h5ddb;
    rst         = 1'b1;
    svc_rd_idx  = '0;
    svc_wr_en   = 1'b0;
    svc_wr_idx  = '0;
    svc_wr_data = '0;
    svc_done    = 1'b0;
    svc_absent  = 1'b0;
    svc_rsp_len = '0;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    chk("busy", 0, busy);
    chk("product_item", 1, product_item);
    op(msm_pkg::FC_RD_INPUT, msm_pkg::LEN_REG_ADDR, 0, 0, 0);
    for (int i = 0; i < 4; i++)
    begin
      w = 16'($random(seed));
      op(msm_pkg::FC_DIAG, msm_pkg::DIAG_ECHO_SUB, w, w, 0);
    end
    op(msm_pkg::FC_RD_HOLD, 16'h0202, 0, 0, 1);
    w = 16'($random(seed));
    op(msm_pkg::FC_WR_REG, msm_pkg::BUF_LAST_ADDR, w, w, 0);
    op(msm_pkg::FC_RD_HOLD, msm_pkg::BUF_LAST_ADDR, 0, w, 0);
    for (int t = 0; t < 2; t++)
    begin
      nv = '0;
      for (int e = 0; e < (t ? 8 : 4); e++)
      begin
        w = 16'($random(seed));
        nv[16*e +: 16] = w;
        op(e == (t ? 7 : 3) ? msm_pkg::FC_WR_REGS : msm_pkg::FC_WR_REG,
           (t ? msm_pkg::TXT_BASE_ADDR : msm_pkg::NUM_BASE_ADDR) + 16'(e),
           w, w, 0);
        chk("commit", e == (t ? 7 : 3),
            t ? txt_commit : num_commit);
        chk("value", e == (t ? 7 : 3) ? nv : 128'h0,
            t ? txt_value : {64'h0, num_value});
      end
    end
    op(msm_pkg::FC_RD_HOLD, msm_pkg::TXT_BASE_ADDR + 16'h0007, 0,
       nv[127:112], 0);
    w = 16'($random(seed));
    op(msm_pkg::FC_WR_REG, msm_pkg::PROD_IDX_ADDR, w, w, 0);
    chk("product_item", 16'(w + 16'h0001), product_item);
    op(msm_pkg::FC_RD_HOLD, msm_pkg::PROD_IDX_ADDR, 0, w, 0);
    op(msm_pkg::FC_WR_COIL, msm_pkg::TRIG_COIL_ADDR,
       msm_pkg::COIL_OFF, msm_pkg::COIL_OFF, 0);
    msm_host_model_i.idle();
    msm_host_model_i.idle();
    chk("coil_off_busy", 0, busy);
    service(16'h0400, 1022, 0, 1022, msm_pkg::RS_NORMAL,
            msm_pkg::FC_WR_COIL);
    service(16'h0001, 4, 0, 2, msm_pkg::RS_NORMAL,
            msm_pkg::FC_WR_COILS);
    service(16'h0abc, 0, 1, 0, msm_pkg::RS_UNKNOWN,
            msm_pkg::FC_WR_COIL);
    service(16'h8002, 4, 0, 0, msm_pkg::RS_ERROR,
            msm_pkg::FC_WR_COIL);
    give_verdict();
  end
endmodule
`default_nettype wire
